/* verilog/thermistor_fault_monitor.sv */
/*
  thermistor supervision: bias pulsing, external source check, fault
  classification, gate control, shutdown and overvoltage sense pulldown.
  assumes analog comparators give levels on pins, and a power-good level.
*/
// Summary of operation
// - bias on only while a reading runs
// - weak sink on during each status check
// - external source present means no bias
// - hot reading turns off both gates
// - near regulator open, near ground short
// - short enters shutdown until charger returns
// - open fault clears after filter time
// - cold acts as open, stays awake
// - pull sense low during overvoltage if enabled
// - pulldown ignores temperature monitor disable
// - charger detect only sampled outside pulldown
// - release 200 ms every 4 s
// - charger sense high means charger, wakes
// - gates off in shutdown or power-up
`timescale 1ns/1ps
`default_nettype none
`include "thermistor_monitor_map.svh"
module thermistor_fault_monitor
  import thermistor_monitor_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = `SAMPLE_PERIOD_CYC,
  parameter int unsigned RELEASE_CYC = `RELEASE_TIME_CYC,
  parameter int unsigned OV_CYC = `OV_PERIOD_CYC,
  parameter int unsigned CHECK_CYC = `CHECK_TIME_CYC,
  parameter int unsigned BIAS_CYC = `BIAS_TIME_CYC
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic power_good, // regulator up, power-up done
  input wire logic ext_pullup_cmp, // sense above external pullup level
  input wire logic hot_cmp, // sense below hot trip level
  input wire logic open_cmp, // sense above open sensor level
  input wire logic short_cmp, // sense below shorted sensor level
  input wire logic charger_sense_cmp, // charger sense above 0.5 V
  input wire logic cell_overvoltage_fault, // overvoltage present
  input wire logic overvoltage_sense_signal_enable, // config bit
  input wire logic temperature_monitor_disable, // config bit
  output logic thermistor_bias_output, // bias supply enable
  output logic weak_sink_enable, // 1 uA sink on sense pin
  output logic sense_pulldown_enable, // hard pulldown on sense pin
  output logic charge_gate_output, // charge gate on
  output logic discharge_gate_output, // discharge gate on
  output logic shutdown_request, // regulator off request
  output logic over_temp_flag, // overtemperature seen
  output logic open_fault_flag, // open or cold seen
  output logic charger_present // charger detected
);
  logic ext_s, hot_s, open_s, short_s, chg_s, pg_s;
  sync2 u_s_ext (.clk(clk), .srst(srst), .async_in(ext_pullup_cmp), .sync_out(ext_s));
  sync2 u_s_hot (.clk(clk), .srst(srst), .async_in(hot_cmp), .sync_out(hot_s));
  sync2 u_s_open (.clk(clk), .srst(srst), .async_in(open_cmp), .sync_out(open_s));
  sync2 u_s_short (.clk(clk), .srst(srst), .async_in(short_cmp), .sync_out(short_s));
  sync2 u_s_chg (.clk(clk), .srst(srst), .async_in(charger_sense_cmp), .sync_out(chg_s));
  sync2 u_s_pg (.clk(clk), .srst(srst), .async_in(power_good), .sync_out(pg_s));

  logic sample_tick, phase_done;
  logic ov_tick, rel_done;
  logic [31:0] phase_limit;
  logic phase_restart;
  interval_timer u_sample (.clk(clk), .srst(srst), .restart(1'b0),
    .limit(SAMPLE_CYC), .done(sample_tick));
  interval_timer u_phase (.clk(clk), .srst(srst), .restart(phase_restart),
    .limit(phase_limit), .done(phase_done));
  interval_timer u_ov (.clk(clk), .srst(srst), .restart(1'b0),
    .limit(OV_CYC), .done(ov_tick));

  read_state_t state_q, state_d;
  temp_class_t class_q, class_d;
  logic ext_q, ext_d;
  logic [3:0] clear_q, clear_d;
  logic [31:0] rel_q, rel_d;
  logic pulling;
  logic chg_prev_q, chg_prev_d, chg_rise;
  logic chg_avail;
  logic bias_d, sink_d, pull_d, cg_d, dg_d, sd_d, hotf_d, openf_d, chp_d;

  // sense pin released for a window each ov period
  always_comb begin
    rel_d = rel_q;
    if (ov_tick) begin
      rel_d = RELEASE_CYC;
    end else if (rel_q != `COUNT_RESET) begin
      rel_d = rel_q - 32'h0000_0001;
    end
  end
  assign rel_done = (rel_q == `COUNT_RESET);
  // pulldown independent of monitor disable
  assign pulling = overvoltage_sense_signal_enable && cell_overvoltage_fault
    && rel_done;
  assign chg_avail = chg_s && !pulling;
  // wake needs a fresh insertion, not a charger already there at the short
  assign chg_rise = chg_avail && !chg_prev_q;

  always_comb begin
    state_d = state_q;
    class_d = class_q;
    ext_d = ext_q;
    clear_d = clear_q;
    chg_prev_d = chg_avail;
    phase_restart = 1'b0;
    phase_limit = CHECK_CYC;
    unique case (state_q)
      st_idle: begin
        if (sample_tick && !temperature_monitor_disable && !pulling) begin
          state_d = st_check;
          phase_restart = 1'b1;
        end
      end
      st_check: begin
        phase_limit = CHECK_CYC;
        if (pulling) begin
          // own pulldown would read as a short, so drop the reading
          state_d = st_idle;
        end else if (phase_done) begin
          ext_d = ext_s;
          if (ext_s) begin
            state_d = st_idle;
          end else begin
            state_d = st_bias;
            phase_restart = 1'b1;
          end
        end
      end
      st_bias: begin
        phase_limit = BIAS_CYC;
        if (pulling || phase_done) begin
          state_d = st_idle;
        end
      end
      st_shutdown: begin
        if (chg_rise) begin
          state_d = st_idle;
          class_d = cls_normal;
        end
      end
      default: state_d = st_idle;
    endcase
    // classify at end of the reading window only
    if (phase_done && !pulling
        && ((state_q == st_check && ext_s) || state_q == st_bias)) begin
      if (short_s) begin
        class_d = cls_short;
        state_d = st_shutdown;
      end else if (open_s) begin
        class_d = cls_open;
        clear_d = 4'h0;
      end else if (class_q == cls_open && clear_q < 4'(`FILTER_READINGS - 1)) begin
        clear_d = clear_q + 4'h1;
      end else if (hot_s) begin
        class_d = cls_hot;
      end else begin
        class_d = cls_normal;
      end
    end
    if (temperature_monitor_disable && state_q != st_shutdown) begin
      class_d = cls_normal;
    end
  end

  always_comb begin
    bias_d = (state_d == st_bias);
    sink_d = (state_d == st_check);
    pull_d = pulling;
    sd_d = (state_d == st_shutdown);
    cg_d = pg_s && !sd_d && (class_d == cls_normal);
    dg_d = cg_d;
    hotf_d = (class_d == cls_hot);
    openf_d = (class_d == cls_open);
    chp_d = pulling ? charger_present : chg_s;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= st_idle;
      class_q <= cls_normal;
      ext_q <= 1'b0;
      clear_q <= 4'h0;
      chg_prev_q <= 1'b0;
      rel_q <= `COUNT_RESET;
      thermistor_bias_output <= 1'b0;
      weak_sink_enable <= 1'b0;
      sense_pulldown_enable <= 1'b0;
      charge_gate_output <= 1'b0;
      discharge_gate_output <= 1'b0;
      shutdown_request <= 1'b0;
      over_temp_flag <= 1'b0;
      open_fault_flag <= 1'b0;
      charger_present <= 1'b0;
    end else begin
      state_q <= state_d;
      class_q <= class_d;
      ext_q <= ext_d;
      clear_q <= clear_d;
      chg_prev_q <= chg_prev_d;
      rel_q <= rel_d;
      thermistor_bias_output <= bias_d;
      weak_sink_enable <= sink_d;
      sense_pulldown_enable <= pull_d;
      charge_gate_output <= cg_d;
      discharge_gate_output <= dg_d;
      shutdown_request <= sd_d;
      over_temp_flag <= hotf_d;
      open_fault_flag <= openf_d;
      charger_present <= chp_d;
    end
  end

  a_bias_only_bias: assert property (@(posedge clk) disable iff (srst)
    thermistor_bias_output |-> $past(state_q) == st_bias || state_q == st_bias)
    else $error("bias on outside reading");
  a_sink_check: assert property (@(posedge clk) disable iff (srst)
    (state_q == st_check) |=> weak_sink_enable || state_q != st_check)
    else $error("sink off during check");
  a_ext_no_bias: assert property (@(posedge clk) disable iff (srst)
    (state_q == st_check && phase_done && ext_s) |=> state_q != st_bias)
    else $error("bias after external source");
  a_hot_gates_off: assert property (@(posedge clk) disable iff (srst)
    (class_q == cls_hot) |-> !charge_gate_output && !discharge_gate_output)
    else $error("gates on while hot");
  a_short_shutdown: assert property (@(posedge clk) disable iff (srst)
    (class_q == cls_short) |-> state_q == st_shutdown)
    else $error("short without shutdown");
  a_shutdown_gates: assert property (@(posedge clk) disable iff (srst)
    shutdown_request |-> !charge_gate_output && !discharge_gate_output)
    else $error("gates on in shutdown");
  a_powerup_gates: assert property (@(posedge clk) disable iff (srst)
    !pg_s |=> !charge_gate_output && !discharge_gate_output)
    else $error("gates on before power good");
  a_wake_charger: assert property (@(posedge clk) disable iff (srst)
    (state_q == st_shutdown && chg_rise) |=> !shutdown_request)
    else $error("no wake on charger insertion");
  a_ov_pulldown: assert property (@(posedge clk) disable iff (srst)
    (overvoltage_sense_signal_enable && cell_overvoltage_fault && rel_done)
    |=> sense_pulldown_enable)
    else $error("no pulldown during overvoltage");
  a_no_read_pulled: assert property (@(posedge clk) disable iff (srst)
    pulling |=> !weak_sink_enable && !thermistor_bias_output)
    else $error("reading while sense pulled low");
  a_release_window: assert property (@(posedge clk) disable iff (srst)
    ov_tick |=> (!pulling) [*5])
    else $error("pulldown during release window");
  a_release_load: assert property (@(posedge clk) disable iff (srst)
    ov_tick |=> rel_q == RELEASE_CYC)
    else $error("release window not loaded");
  a_charger_held: assert property (@(posedge clk) disable iff (srst)
    pulling |=> charger_present == $past(charger_present))
    else $error("charger state moved during pulldown");
  a_open_gates: assert property (@(posedge clk) disable iff (srst)
    (class_q == cls_open) |-> !shutdown_request && !charge_gate_output)
    else $error("open fault caused shutdown or gates on");
  c_open_clear: cover property (@(posedge clk) disable iff (srst) $fell(open_fault_flag));
  c_hot: cover property (@(posedge clk) disable iff (srst) over_temp_flag);
  c_short: cover property (@(posedge clk) disable iff (srst) shutdown_request);
  c_wake: cover property (@(posedge clk) disable iff (srst)
    state_q == st_shutdown ##1 state_q == st_idle);
  c_pull: cover property (@(posedge clk) disable iff (srst) sense_pulldown_enable);
endmodule
`default_nettype wire

/* verilog/thermistor_monitor_map.svh */
/*
  timing counts and reset values for the thermistor fault monitor.
  assumes a 100 MHz clock.
*/
`ifndef THERMISTOR_MONITOR_MAP_SVH
`define THERMISTOR_MONITOR_MAP_SVH
`define CLK_PERIOD_NS 10
`define SAMPLE_PERIOD_US 100000
`define SAMPLE_PERIOD_CYC ((`SAMPLE_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define CHECK_TIME_US 100
`define CHECK_TIME_CYC (((`CHECK_TIME_US * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BIAS_TIME_US 100
`define BIAS_TIME_CYC (((`BIAS_TIME_US * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RELEASE_TIME_MS 200
`define RELEASE_TIME_CYC ((`RELEASE_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define OV_PERIOD_MS 4000
`define OV_PERIOD_CYC ((`OV_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define FILTER_READINGS 8
`define COUNT_RESET 32'h0000_0000
`endif

/* verilog/thermistor_monitor_pkg.sv */
/*
  types shared by the thermistor fault monitor.
  assumes nothing of its surroundings.
*/
package thermistor_monitor_pkg;
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_check = 4'b0010,
    st_bias = 4'b0100,
    st_shutdown = 4'b1000
  } read_state_t;
  typedef enum logic [2:0] {
    cls_normal = 3'b000,
    cls_hot = 3'b001,
    cls_open = 3'b010,
    cls_short = 3'b100
  } temp_class_t;
endpackage

/* verilog/sync2.sv */
/*
  two-flop synchroniser for one asynchronous level.
  assumes input comes from a pin or a comparator output.
*/
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic async_in, // asynchronous level
  output logic sync_out // synchronised level
);
  logic meta_q;
  logic meta_d;
  logic sync_d;
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_out <= sync_d;
    end
  end
endmodule
`default_nettype wire

/* verilog/interval_timer.sv */
/*
  free counter that pulses done after a settable number of cycles.
  assumes restart is a one-cycle pulse from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "thermistor_monitor_map.svh"
module interval_timer (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic restart, // reload counter
  input wire logic [31:0] limit, // cycles per interval
  output logic done // one-cycle pulse at end
);
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic done_d;
  always_comb begin
    done_d = 1'b0;
    count_d = count_q + 32'h0000_0001;
    if (restart) begin
      count_d = `COUNT_RESET;
    end else if (count_q >= limit - 32'h0000_0001) begin
      count_d = `COUNT_RESET;
      done_d = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= `COUNT_RESET;
      done <= 1'b0;
    end else begin
      count_q <= count_d;
      done <= done_d;
    end
  end
endmodule
`default_nettype wire

/* verification/therm_model.sv */
/*
  far side: thermistor with optional charger pullup and charger sense pin.
  assumes a level code from the bench: 0 short, 1 hot, 2 normal, 3 open.
*/
`timescale 1ns/1ps
`default_nettype none
module therm_model (
  input wire logic bias, // bias supply on
  input wire logic sink, // weak sink on
  input wire logic pull_low, // hard pulldown on sense pin
  input wire logic ext_on, // charger drives sense node
  input wire logic [1:0] level, // thermistor level code
  input wire logic charger_on, // charger on sense pin
  output logic ext_pullup_cmp, // sense above external pullup level
  output logic hot_cmp, // sense below hot trip level
  output logic open_cmp, // sense above open level
  output logic short_cmp, // sense below short level
  output logic charger_sense_cmp // charger sense above 0.5 V
);
  logic driven;
  // unbiased or pulled node reads as ground
  assign driven = (bias || ext_on) && !pull_low;
  assign ext_pullup_cmp = ext_on && !pull_low && sink;
  assign hot_cmp = !driven || (level <= 2'h1);
  assign open_cmp = driven && (level == 2'h3);
  assign short_cmp = !driven || (level == 2'h0);
  assign charger_sense_cmp = charger_on;
endmodule
`default_nettype wire

/* verification/tb_top.sv */
/*
  self-checking bench for the thermistor fault monitor.
  assumes shortened sample, release and overvoltage periods.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import thermistor_monitor_pkg::*;
  logic clk, srst, power_good, ext_on, charger_on, ov_fault, ov_en, tmp_dis;
  logic [1:0] level;
  logic ext_cmp, hot, open, short, chg_cmp;
  logic bias, sink, pull, chg_g, dsg_g, shut, ot_flag, open_flag, chg_pres;
  int n_fail, comparisons;
  int cyc = 0;
  therm_model therm_model_i (.bias(bias), .sink(sink), .pull_low(pull), .ext_on(ext_on),
    .level(level), .charger_on(charger_on), .ext_pullup_cmp(ext_cmp), .hot_cmp(hot),
    .open_cmp(open), .short_cmp(short), .charger_sense_cmp(chg_cmp));
  thermistor_fault_monitor #(.SAMPLE_CYC(50), .RELEASE_CYC(5), .OV_CYC(40), .CHECK_CYC(20),
    .BIAS_CYC(20))
  thermistor_fault_monitor_i (.clk(clk), .srst(srst), .power_good(power_good),
    .ext_pullup_cmp(ext_cmp), .hot_cmp(hot), .open_cmp(open), .short_cmp(short),
    .charger_sense_cmp(chg_cmp), .cell_overvoltage_fault(ov_fault),
    .overvoltage_sense_signal_enable(ov_en), .temperature_monitor_disable(tmp_dis),
    .thermistor_bias_output(bias), .weak_sink_enable(sink), .sense_pulldown_enable(pull),
    .charge_gate_output(chg_g), .discharge_gate_output(dsg_g), .shutdown_request(shut),
    .over_temp_flag(ot_flag), .open_fault_flag(open_flag), .charger_present(chg_pres));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("counts: %0d compared, %0d bad", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait: 0 weak sink, 1 bias, 2 pulldown
  task automatic wait_sig(input int which, input logic val, input int lim);
    int i;
    logic s;
    for (i = 0; i < lim; i++) begin
      s = (which == 0) ? sink : (which == 1) ? bias : pull;
      if (s === val) break;
      tick(1);
    end
    check("wait", {7'h00, s}, {7'h00, val});
  endtask
  task automatic reading(input logic exp_bias);
    wait_sig(0, 1'b1, 300);
    check("bias_in_check", {7'h00, bias}, 8'h00);
    wait_sig(0, 1'b0, 100);
    tick(1);
    check("bias_after_check", {7'h00, bias}, {7'h00, exp_bias});
    if (exp_bias) wait_sig(1, 1'b0, 100);
    tick(3);
    check("bias_idle", {7'h00, bias}, 8'h00);
  endtask
  task automatic gates(input string tn, input logic g, input logic ot, input logic op,
                       input logic sd);
    check("gates", {6'h00, chg_g, dsg_g}, {6'h00, g, g});
    check("flags", {5'h00, ot_flag, open_flag, shut}, {5'h00, ot, op, sd});
    $display("test %s done", tn);
  endtask
  task automatic test_normal_hot();
    level = 2'h2;
    reading(1'b1);
    gates("normal", 1'b1, 1'b0, 1'b0, 1'b0);
    level = 2'h1;
    reading(1'b1);
    gates("hot", 1'b0, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic test_ext();
    ext_on = 1'b1;
    level = 2'h2;
    reading(1'b0);
    ext_on = 1'b0;
    gates("ext", 1'b1, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic test_ov();
    int lows;
    tmp_dis = 1'b1;
    ov_en = 1'b1;
    ov_fault = 1'b1;
    tick(2);
    wait_sig(2, 1'b1, 10);
    check("pulldown", {7'h00, pull}, 8'h01);
    wait_sig(2, 1'b0, 60);
    wait_sig(2, 1'b1, 60);
    charger_on = 1'b1;
    tick(3);
    check("chg_held", {7'h00, chg_pres}, 8'h00);
    lows = 0;
    repeat (80) begin
      tick(1);
      if (pull !== 1'b1) lows++;
    end
    check("release_lo", {7'h00, lows >= 5}, 8'h01);
    check("release_hi", {7'h00, lows <= 15}, 8'h01);
    check("chg_sampled", {7'h00, chg_pres}, 8'h01);
    ov_fault = 1'b0;
    charger_on = 1'b0;
    tick(4);
    check("pull_off", {6'h00, pull, chg_pres}, 8'h00);
    ov_en = 1'b0;
    tmp_dis = 1'b0;
    $display("test ov done");
  endtask
  task automatic test_open_short();
    level = 2'h3;
    reading(1'b1);
    gates("open", 1'b0, 1'b0, 1'b1, 1'b0);
    level = 2'h2;
    repeat (7) reading(1'b1);
    check("open_held", {7'h00, open_flag}, 8'h01);
    reading(1'b1);
    gates("open_clear", 1'b1, 1'b0, 1'b0, 1'b0);
    level = 2'h0;
    reading(1'b1);
    gates("short", 1'b0, 1'b0, 1'b0, 1'b1);
    level = 2'h2;
    charger_on = 1'b1;
    tick(10);
    check("wake", {6'h00, shut, chg_pres}, 8'h01);
    check("wake_gates", {6'h00, chg_g, dsg_g}, 8'h03);
    $display("test wake done");
  endtask
  initial begin
    {srst, power_good, ext_on, charger_on, ov_fault, ov_en, tmp_dis} = 7'h01 << 6;
    level = 2'h2;
    n_fail = 0;
    comparisons = 0;
    tick(4);
    srst = 1'b0;
    tick(30);
    check("powerup_gates", {6'h00, chg_g, dsg_g}, 8'h00);
    power_good = 1'b1;
    test_normal_hot();
    test_ext();
    test_ov();
    test_open_short();
    stop_test();
  end
endmodule
`default_nettype wire
